// File: verilog/gp_pin_cfg.svh
`ifndef GP_PIN_CFG_SVH
`define GP_PIN_CFG_SVH
// Host I/O addresses of the three configuration ports.
`define CFG_ENABLE_ADDR 11'h250
`define CFG_INDEX_ADDR 11'h251
`define CFG_DATA_ADDR 11'h252
// Value that opens the configuration ports.
`define CFG_UNLOCK_KEY 8'h89
// Register indices reached through the data port.
`define IDX_PIN_ZERO_ADDR_LOW 8'h10
`define IDX_PIN_ZERO_ADDR_HIGH_SPAN 8'h11
`define IDX_PIN_ONE_ADDR_LOW 8'h12
`define IDX_PIN_ONE_ADDR_HIGH_SPAN 8'h13
`define IDX_PIN_ZERO_MODE_CONFIG 8'h14
`define IDX_PIN_ONE_MODE_CONFIG 8'h15
`define IDX_FIRST 8'h10
`define IDX_LAST 8'h15
// Slot of the first mode register in the register array.
`define SLOT_MODE_BASE 4
// Power-on value of every register.
`define CFG_RESET_VALUE 8'h00
// Mode register field positions.
`define MODE_FIELD_MSB 7
`define MODE_FIELD_LSB 5
`define SELECT_HIGH_ACTIVE_BIT 4
`define SELECT_ON_READ_BIT 3
`define SELECT_ON_WRITE_BIT 2
`define INVERT_TO_PIN_BIT 1
`define INVERT_FROM_PIN_BIT 0
// High address register field positions.
`define SPAN_FIELD_MSB 7
`define SPAN_FIELD_LSB 6
`define ADDR_UPPER_MSB 2
`endif

// File: verilog/gp_pin_pkg.sv
package gp_pin_pkg;

    // Working mode of one general-purpose pin.
    typedef enum logic [2:0] {
        MODE_TRISTATE,
        MODE_OUTPUT,
        MODE_INPUT,
        MODE_BIDIR,
        MODE_SELECT
    } pin_mode_t;

    // State of the top module apart from the reset synchroniser.
    typedef struct packed {
        logic cfg_open;
        logic [7:0] cfg_index;
        logic [5:0][7:0] regs;
        logic iow_prev;
        logic [1:0] pin_data;
        logic [1:0] pin_out;
        logic [1:0] pin_oe_b;
        logic [7:0] sd_out;
        logic sd_oe_b;
    } gp_state_t;

    // Turns the three-bit mode field into a working mode.
    function automatic pin_mode_t decode_mode(input logic [2:0] field);
        pin_mode_t m;
        m = MODE_TRISTATE;
        if (field[2])
        begin
            m = MODE_SELECT;
        end
        else
        begin
            case (field[1:0])
                2'h1: m = MODE_OUTPUT;
                2'h2: m = MODE_INPUT;
                2'h3: m = MODE_BIDIR;
                default: m = MODE_TRISTATE;
            endcase
        end
        return m;
    endfunction

endpackage

// File: verilog/gp_pin_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "gp_pin_cfg.svh"
// Combinational address and strobe decode for one pin.
module gp_pin_unit
    import gp_pin_pkg::*;
(
    input wire logic [10:0] sa_in,
    input wire logic aen_in,
    input wire logic ior_b_in,
    input wire logic iow_b_in,
    input wire logic [7:0] addr_low_in,
    input wire logic [7:0] addr_high_in,
    input wire logic [7:0] mode_cfg_in,
    output logic wr_hit_out,
    output logic rd_hit_out,
    output logic select_on_out
);

    logic [10:0] match_addr; // Configured pin address.
    logic [10:0] span_mask; // Address bits that take part in the compare.
    logic match; // Bus address hits the pin address.

    // Only the lower three bits of the high register join the address.
    assign match_addr = {addr_high_in[`ADDR_UPPER_MSB:0], addr_low_in};

    // R11 span mask
    assign span_mask = 11'h7FF << addr_high_in[`SPAN_FIELD_MSB:`SPAN_FIELD_LSB];

    // R12 address compare
    assign match = !aen_in && (((sa_in ^ match_addr) & span_mask) == 11'h000);

    assign wr_hit_out = match && !iow_b_in;
    assign rd_hit_out = match && !ior_b_in;

    // Strobe qualification for chip-select use.
    always_comb
    begin
        // R7 strobe qualifier
        case ({mode_cfg_in[`SELECT_ON_READ_BIT], mode_cfg_in[`SELECT_ON_WRITE_BIT]})
            2'h0: select_on_out = match;
            2'h1: select_on_out = wr_hit_out;
            2'h2: select_on_out = rd_hit_out;
            default: select_on_out = wr_hit_out || rd_hit_out;
        endcase
    end

endmodule
`default_nettype wire

// File: verilog/gp_pin_decode_select.sv
// Overview of operation
// R1 - Three-bit mode field: tristate, output, input, bidirectional or chip select.
// R2 - Output mode drives host bit onto pin.
// R3 - Input mode returns pin level on read.
// R4 - Bidirectional mode latches writes, returns reads.
// R5 - Select mode asserts pin on qualified match.
// R6 - Polarity bit picks low or high assertion.
// R7 - Qualifier bits: match, write, read, either.
// R8 - Two bits invert each data direction.
// R9 - Unlock key, index, then data access.
// R10 - Registers clear to zero at power-on.
// R11 - Span field ignores low address bits.
// R12 - Address split over low and high register.
// R13 - Host data undriven unless read hits.
`timescale 1ns/1ps
`default_nettype none
`include "gp_pin_cfg.svh"
module gp_pin_decode_select
    import gp_pin_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic [10:0] sa_in,
    input wire logic aen_in,
    input wire logic ior_b_in,
    input wire logic iow_b_in,
    input wire logic [7:0] sd_in,
    output logic [7:0] sd_out,
    output logic sd_oe_b_out,
    input wire logic gp_pin_zero_in,
    output logic gp_pin_zero_out,
    output logic gp_pin_zero_oe_b_out,
    input wire logic gp_pin_one_in,
    output logic gp_pin_one_out,
    output logic gp_pin_one_oe_b_out
);

    logic rst_meta_q; // First reset synchroniser stage.
    logic rst_n_q; // Released reset used by all logic.
    gp_state_t q; // Registered state.
    gp_state_t d; // Next state.
    logic [1:0] wr_hit; // Write hits per pin.
    logic [1:0] rd_hit; // Read hits per pin.
    logic [1:0] select_on; // Qualified select per pin.
    logic [1:0] pin_in; // Pin levels gathered for the loop.
    logic iow_fall; // Write strobe just went low.

    // Release of the reset is made synchronous so no flop sees a runt edge.
    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    assign pin_in = {gp_pin_one_in, gp_pin_zero_in};

    // One decoder per pin; the pins differ only in their registers.
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_pin
            // R12 address halves
            gp_pin_unit u_unit (
                .sa_in(sa_in),
                .aen_in(aen_in),
                .ior_b_in(ior_b_in),
                .iow_b_in(iow_b_in),
                .addr_low_in(q.regs[2 * gi]),
                .addr_high_in(q.regs[2 * gi + 1]),
                .mode_cfg_in(q.regs[`SLOT_MODE_BASE + gi]),
                .wr_hit_out(wr_hit[gi]),
                .rd_hit_out(rd_hit[gi]),
                .select_on_out(select_on[gi])
            );
        end
    endgenerate

    // Configuration writes act once per strobe, so a long strobe is harmless.
    assign iow_fall = !iow_b_in && q.iow_prev;

    // Next-state logic for the whole block.
    always_comb
    begin
        pin_mode_t mode;
        logic [7:0] mcfg;
        logic [7:0] slot;
        d = q;
        mode = MODE_TRISTATE;
        mcfg = 8'h00;
        slot = q.cfg_index - `IDX_FIRST;
        d.iow_prev = iow_b_in;
        d.sd_out = 8'h00;
        d.sd_oe_b = 1'b1;
        // R9 configuration ports
        if (iow_fall && !aen_in)
        begin
            if (sa_in == `CFG_ENABLE_ADDR)
            begin
                // Any other value closes the ports again.
                d.cfg_open = (sd_in == `CFG_UNLOCK_KEY);
            end
            else if (q.cfg_open && sa_in == `CFG_INDEX_ADDR)
            begin
                d.cfg_index = sd_in;
            end
            else if (q.cfg_open && sa_in == `CFG_DATA_ADDR &&
                     q.cfg_index >= `IDX_FIRST && q.cfg_index <= `IDX_LAST)
            begin
                d.regs[slot[2:0]] = sd_in;
            end
        end
        // R9 configuration reads
        if (!ior_b_in && !aen_in && q.cfg_open)
        begin
            if (sa_in == `CFG_INDEX_ADDR)
            begin
                d.sd_out = q.cfg_index;
                d.sd_oe_b = 1'b0;
            end
            else if (sa_in == `CFG_DATA_ADDR)
            begin
                // Unmapped indices read as zero.
                if (q.cfg_index >= `IDX_FIRST && q.cfg_index <= `IDX_LAST)
                begin
                    d.sd_out = q.regs[slot[2:0]];
                end
                d.sd_oe_b = 1'b0;
            end
        end
        for (int i = 0; i < 2; i++)
        begin
            mcfg = q.regs[`SLOT_MODE_BASE + i];
            // R1 mode decode
            mode = decode_mode(mcfg[`MODE_FIELD_MSB:`MODE_FIELD_LSB]);
            // R2 R4 write latch
            if ((mode == MODE_OUTPUT || mode == MODE_BIDIR) && wr_hit[i])
            begin
                d.pin_data[i] = sd_in[0];
            end
            case (mode)
                MODE_SELECT:
                begin
                    // R5 R6 select level
                    d.pin_out[i] = select_on[i] ? mcfg[`SELECT_HIGH_ACTIVE_BIT] :
                                   !mcfg[`SELECT_HIGH_ACTIVE_BIT];
                    d.pin_oe_b[i] = 1'b0;
                end
                MODE_OUTPUT, MODE_BIDIR:
                begin
                    // R8 invert to pin
                    d.pin_out[i] = d.pin_data[i] ^ mcfg[`INVERT_TO_PIN_BIT];
                    d.pin_oe_b[i] = 1'b0;
                end
                default:
                begin
                    // Tristate and input modes leave the pin to the peripheral.
                    d.pin_out[i] = 1'b0;
                    d.pin_oe_b[i] = 1'b1;
                end
            endcase
            // R3 R4 R13 pin read
            if ((mode == MODE_INPUT || mode == MODE_BIDIR) && rd_hit[i])
            begin
                // R8 invert from pin
                d.sd_out = {7'h00, pin_in[i] ^ mcfg[`INVERT_FROM_PIN_BIT]};
                d.sd_oe_b = 1'b0;
            end
        end
    end

    // State register; every field has a reset value.
    always_ff @(posedge core_clk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            q.cfg_open <= 1'b0;
            q.cfg_index <= 8'h00;
            // R10 power-on clear
            q.regs <= {6{`CFG_RESET_VALUE}};
            q.iow_prev <= 1'b1;
            q.pin_data <= 2'h0;
            q.pin_out <= 2'h0;
            q.pin_oe_b <= 2'h3;
            q.sd_out <= 8'h00;
            q.sd_oe_b <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign sd_out = q.sd_out;
    assign sd_oe_b_out = q.sd_oe_b;
    assign gp_pin_zero_out = q.pin_out[0];
    assign gp_pin_zero_oe_b_out = q.pin_oe_b[0];
    assign gp_pin_one_out = q.pin_out[1];
    assign gp_pin_one_oe_b_out = q.pin_oe_b[1];

    // Checks on pin one, whose mode register sits in slot five, and on unlock, reset and bus idle.
    logic [7:0] m1; // Pin one mode register.
    assign m1 = q.regs[`SLOT_MODE_BASE + 1];

    sequence s_unlock;
        iow_fall && !aen_in && sa_in == `CFG_ENABLE_ADDR && sd_in == `CFG_UNLOCK_KEY;
    endsequence
    sequence s_data_write;
        iow_fall && !aen_in && q.cfg_open && sa_in == `CFG_DATA_ADDR &&
        q.cfg_index == `IDX_PIN_ONE_MODE_CONFIG;
    endsequence

    property p_tristate;
        @(posedge core_clk_in) disable iff (!rst_n_q)
        (m1[7:5] == 3'h0 && $stable(m1)) |=> gp_pin_one_oe_b_out;
    endproperty
    a_tristate: assert property (p_tristate) else $error("pin not tristated"); // R1

    property p_out_drive;
        @(posedge core_clk_in) disable iff (!rst_n_q)
        (m1[7:5] == 3'h1 && wr_hit[1]) |=>
            !gp_pin_one_oe_b_out && gp_pin_one_out == ($past(sd_in[0]) ^ $past(m1[1]));
    endproperty
    a_out_drive: assert property (p_out_drive) else $error("output bit wrong"); // R2

    property p_in_read;
        @(posedge core_clk_in) disable iff (!rst_n_q)
        (m1[7:5] == 3'h2 && rd_hit[1]) |=>
            !sd_oe_b_out && sd_out == {7'h00, $past(gp_pin_one_in) ^ $past(m1[0])};
    endproperty
    a_in_read: assert property (p_in_read) else $error("input read wrong"); // R3

    property p_bidir_hold;
        @(posedge core_clk_in) disable iff (!rst_n_q)
        (m1[7:5] == 3'h3 && wr_hit[1] ##1 (m1[7:5] == 3'h3 && !wr_hit[1]) [*2]) |=>
            gp_pin_one_out == $past(gp_pin_one_out);
    endproperty
    a_bidir_hold: assert property (p_bidir_hold) else $error("latched bit lost"); // R4

    property p_select;
        @(posedge core_clk_in) disable iff (!rst_n_q)
        (m1[7] && $stable(m1) && select_on[1]) |=>
            !gp_pin_one_oe_b_out && gp_pin_one_out == $past(m1[4]);
    endproperty
    a_select: assert property (p_select) else $error("select level wrong"); // R6

    property p_qualifier;
        @(posedge core_clk_in) disable iff (!rst_n_q)
        (m1[7] && m1[3:2] == 2'h1 && iow_b_in && $stable(m1)) |=>
            gp_pin_one_out == !$past(m1[4]);
    endproperty
    a_qualifier: assert property (p_qualifier) else $error("select without write"); // R7

    property p_config_write;
        @(posedge core_clk_in) disable iff (!rst_n_q)
        s_data_write |=> q.regs[`SLOT_MODE_BASE + 1] == $past(sd_in);
    endproperty
    a_config_write: assert property (p_config_write) else $error("register not written"); // R9

    property p_unlock;
        @(posedge core_clk_in) disable iff (!rst_n_q)
        s_unlock |=> q.cfg_open;
    endproperty
    a_unlock: assert property (p_unlock) else $error("ports not opened"); // R9

    property p_reset_clear;
        @(posedge core_clk_in)
        $rose(rst_n_q) |-> q.regs == 48'h0 && gp_pin_one_oe_b_out && sd_oe_b_out;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset value wrong"); // R10

    property p_bus_idle;
        @(posedge core_clk_in) disable iff (!rst_n_q)
        (ior_b_in || aen_in) |=> sd_oe_b_out;
    endproperty
    a_bus_idle: assert property (p_bus_idle) else $error("bus driven without read"); // R13

endmodule
`default_nettype wire

// File: sim/gp_peripheral_model.sv
`timescale 1ns/1ps
`default_nettype none
// Peripheral on the two pins: it drives its own level whenever the device lets a pin go.
module gp_peripheral_model
(
    input wire logic [1:0] drive_in,
    input wire logic [1:0] dev_out_in,
    input wire logic [1:0] dev_oe_b_in,
    output logic [1:0] level_out
);
    // A driven pin shows the device value, so a bidirectional read sees what was written.
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            level_out[i] = dev_oe_b_in[i] ? drive_in[i] : dev_out_in[i];
        end
    end
endmodule
`default_nettype wire

// File: sim/gp_pin_decode_select_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "gp_pin_cfg.svh"
module gp_pin_decode_select_tb;
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic [10:0] sa = 11'h000;
    logic aen = 1'h1;
    logic ior_b = 1'h1;
    logic iow_b = 1'h1;
    logic [7:0] sd_wr = 8'h00;
    logic [7:0] sd_rd;
    logic sd_oe_b;
    logic [1:0] drive = 2'h0;
    logic [1:0] pin_lvl;
    logic [1:0] pin_out;
    logic [1:0] pin_oe_b;
    int errors = 0;
    int n_checks = 0;

    // Free-running 125 MHz clock.
    initial
    begin
        forever #4 clk = ~clk;
    end

    gp_pin_decode_select dut_u (.core_clk_in(clk), .rst_b_in(rst_b), .sa_in(sa), .aen_in(aen),
        .ior_b_in(ior_b), .iow_b_in(iow_b), .sd_in(sd_wr), .sd_out(sd_rd),
        .sd_oe_b_out(sd_oe_b), .gp_pin_zero_in(pin_lvl[0]), .gp_pin_zero_out(pin_out[0]),
        .gp_pin_zero_oe_b_out(pin_oe_b[0]), .gp_pin_one_in(pin_lvl[1]),
        .gp_pin_one_out(pin_out[1]), .gp_pin_one_oe_b_out(pin_oe_b[1]));

    gp_peripheral_model periph_u (.drive_in(drive), .dev_out_in(pin_out),
        .dev_oe_b_in(pin_oe_b), .level_out(pin_lvl));

    // Lets the clock edge land before anything is looked at.
    task automatic step;
        @(posedge clk);
        #1;
    endtask

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            errors++;
        end
    endtask

    // One write cycle; the strobe is high again at the next edge, as back-to-back writes need.
    task automatic bus_wr(input logic [10:0] a, input logic [7:0] d);
        @(posedge clk);
        sa <= a;
        aen <= 1'h0;
        iow_b <= 1'h0;
        sd_wr <= d;
        @(posedge clk);
        iow_b <= 1'h1;
        aen <= 1'h1;
    endtask

    // One read cycle; drv says whether the device is expected to drive the data bus.
    task automatic bus_rd(input logic [10:0] a, input logic [7:0] exp, input logic drv);
        @(posedge clk);
        sa <= a;
        aen <= 1'h0;
        ior_b <= 1'h0;
        step();
        check("sd_oe_b", {7'h0, ~drv}, {7'h0, sd_oe_b});
        if (drv)
        begin
            check("sd", exp, sd_rd);
        end
        @(posedge clk);
        ior_b <= 1'h1;
        aen <= 1'h1;
    endtask

    task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] v);
        bus_wr(`CFG_ENABLE_ADDR, `CFG_UNLOCK_KEY);
        bus_wr(`CFG_INDEX_ADDR, idx);
        bus_wr(`CFG_DATA_ADDR, v);
    endtask

    task automatic cfg_rd(input logic [7:0] idx, input logic [7:0] exp);
        bus_wr(`CFG_ENABLE_ADDR, `CFG_UNLOCK_KEY);
        bus_wr(`CFG_INDEX_ADDR, idx);
        bus_rd(`CFG_DATA_ADDR, exp, 1'h1);
    endtask

    // Holds a match at an address with st = 0 no strobe, 1 write, 2 read; checks pin one.
    task automatic probe(input logic [10:0] a, input int st, input logic exp);
        @(posedge clk);
        sa <= a;
        aen <= 1'h0;
        iow_b <= (st != 1);
        ior_b <= (st != 2);
        step();
        check("pin_one", {7'h0, exp}, {7'h0, pin_out[1]});
        check("pin_one_oe_b", 8'h00, {7'h0, pin_oe_b[1]});
        @(posedge clk);
        aen <= 1'h1;
        iow_b <= 1'h1;
        ior_b <= 1'h1;
    endtask

    task automatic t_regs;
        for (int i = 0; i < 6; i++)
        begin
            cfg_rd(8'(8'h10 + i), 8'h00);
        end
        check("pin_oe_b", 8'h03, {6'h0, pin_oe_b});
        // Closing the ports must also stop the index and data ports.
        bus_wr(`CFG_ENABLE_ADDR, 8'h00);
        bus_wr(`CFG_INDEX_ADDR, 8'h10);
        bus_rd(`CFG_DATA_ADDR, 8'h00, 1'h0);
        cfg_wr(8'h16, 8'h55);
        bus_rd(`CFG_DATA_ADDR, 8'h00, 1'h1);
        for (int i = 0; i < 4; i++)
        begin
            cfg_wr(8'(8'h10 + i), 8'(8'hA5 + i));
            cfg_rd(8'(8'h10 + i), 8'(8'hA5 + i));
        end
    endtask

    // Runs the data modes on pin k, so that both pins and the pin one checkers are exercised.
    task automatic t_data(input int k);
        logic inv;
        logic [7:0] mode_idx;
        mode_idx = 8'(8'h14 + k);
        cfg_wr(8'(8'h10 + 2 * k), 8'hA5);
        cfg_wr(8'(8'h11 + 2 * k), 8'h03);
        for (int i = 0; i < 2; i++)
        begin
            inv = i[0];
            cfg_wr(mode_idx, 8'h20 | {6'h0, inv, 1'h0});
            for (int d = 0; d < 2; d++)
            begin
                bus_wr(11'h3A5, {7'h0, d[0]});
                step();
                step();
                check("pin", {7'h0, d[0] ^ inv}, {7'h0, pin_out[k]});
                check("pin_oe_b", 8'h00, {7'h0, pin_oe_b[k]});
            end
            // A neighbouring address must leave the latched level alone.
            bus_wr(11'h3A4, 8'h00);
            step();
            step();
            check("pin", {7'h0, ~inv}, {7'h0, pin_out[k]});
            cfg_wr(mode_idx, 8'h40 | {7'h0, inv});
            step();
            check("pin_oe_b", 8'h01, {7'h0, pin_oe_b[k]});
            for (int d = 0; d < 2; d++)
            begin
                drive[k] <= d[0];
                bus_rd(11'h3A5, {7'h0, d[0] ^ inv}, 1'h1);
            end
            bus_rd(11'h3A4, 8'h00, 1'h0);
        end
        cfg_wr(mode_idx, 8'h60);
        for (int d = 1; d >= 0; d--)
        begin
            drive[k] <= ~d[0];
            bus_wr(11'h3A5, {7'h0, d[0]});
            bus_rd(11'h3A5, {7'h0, d[0]}, 1'h1);
        end
        cfg_wr(mode_idx, 8'h00);
    endtask

    task automatic t_select;
        logic act;
        cfg_wr(8'h12, 8'hC8);
        cfg_wr(8'h13, 8'h00);
        for (int q = 0; q < 4; q++)
        begin
            for (int p = 0; p < 2; p++)
            begin
                cfg_wr(8'h15, 8'h80 | {3'h0, p[0], q[1:0], 2'h0});
                for (int st = 0; st < 3; st++)
                begin
                    act = (q == 0) || (q == st) || (q == 3 && st != 0);
                    probe(11'h0C8, st, act ? p[0] : ~p[0]);
                end
            end
        end
        // The span field widens the match by whole powers of two.
        cfg_wr(8'h15, 8'h90);
        for (int s = 0; s < 4; s++)
        begin
            cfg_wr(8'h13, {s[1:0], 6'h00});
            probe(11'(11'h0C8 + (1 << s) - 1), 0, 1'h1);
            probe(11'(11'h0C8 + (1 << s)), 0, 1'h0);
        end
    endtask

    task automatic stop_test;
        if (errors == 0 && n_checks > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Reset for five cycles, then wait until the bus may be used.
    initial
    begin
        repeat (5) @(posedge clk);
        rst_b <= 1'h1;
        repeat (4) @(posedge clk);
        t_regs();
        t_data(0);
        t_data(1);
        t_select();
        stop_test();
    end
endmodule
`default_nettype wire
